// file: rtl/rot_left_defines.vh
/*
  constants for the rotate-left-without-carry execution unit.
  assumes plain verilog-2005 inclusion by bare name.
*/
`ifndef ROT_LEFT_DEFINES_VH
`define ROT_LEFT_DEFINES_VH
// ----------------------------------------
// instruction encoding
// ----------------------------------------
`define RL_OPCODE       6'h11
`define RL_OPC_HI       15
`define RL_OPC_LO       10
`define RL_DEST_BIT     9
`define RL_ACCESS_BIT   8
// ----------------------------------------
// addressing
// ----------------------------------------
`define RL_INDEX_LIMIT  8'h5f
`define RL_ACC_HI_BANK  4'hf
`define RL_ACC_LO_BANK  4'h0
// ----------------------------------------
// quarter phases, one-hot
// ----------------------------------------
`define RL_Q1           4'h1
`define RL_Q2           4'h2
`define RL_Q3           4'h4
`define RL_Q4           4'h8
`define RL_RESET_BYTE   8'h00
`endif

// file: rtl/rot_left_bitrot.v
/*
  one-bit circular left rotation of a data byte into a result register.
  assumes the caller strobes load_i once per instruction.
*/
`timescale 1ns/1ps
`include "rot_left_defines.vh"
module rot_left_bitrot #(
  parameter WIDTH = 8
) (
  input wire core_clk_i,
  input wire arst_n_i,
  input wire clk_en_i,
  input wire load_i,
  input wire [WIDTH-1:0] data_i,
  output reg [WIDTH-1:0] result_o
);
  wire [WIDTH-1:0] rot_nxt;
  genvar g;
  // ----------------------------------------
  // rotation, bit n moves to n+1, msb to lsb
  // ----------------------------------------
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_rot
      if (g == 0) begin : g_wrap
        assign rot_nxt[0] = data_i[WIDTH-1];
      end else begin : g_shift
        assign rot_nxt[g] = data_i[g-1];
      end
    end
  endgenerate

  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      result_o <= {WIDTH{1'b0}};
    end else if (clk_en_i && load_i) begin
      result_o <= rot_nxt;
    end
  end
endmodule // rot_left_bitrot

// file: rtl/rotate_left_no_carry_exec.v
/*
  execution of the rotate-left-without-carry byte instruction over four
  quarter phases: decode, file read, process, destination write.
  assumes the file memory returns read data combinationally in the read
  phase and accepts a one-cycle write strobe; ext_set_i is static.
  clk_en_i low holds every register, so the four phases simply stretch.
*/
`timescale 1ns/1ps
`include "rot_left_defines.vh"
module rotate_left_no_carry_exec #(
  parameter WIDTH = 8
) (
  input wire core_clk_i,
  input wire arst_n_i,
  input wire clk_en_i,
  input wire start_i,
  input wire [15:0] instr_i,
  input wire ext_set_i,
  input wire [3:0] bank_select_reg_i,
  input wire [7:0] index_base_i,
  input wire [WIDTH-1:0] file_rdata_i,
  output wire [11:0] file_addr_o,
  output wire file_rd_o,
  output reg file_wr_o,
  output wire [WIDTH-1:0] file_wdata_o,
  output reg [WIDTH-1:0] wreg_o,
  output reg wreg_wr_o,
  output reg neg_o,
  output reg zero_o,
  output reg flags_wr_o,
  output wire busy_o,
  output reg illegal_o
);
  localparam IDLE = 5'h01;
  localparam Q1 = 5'h02;
  localparam Q2 = 5'h04;
  localparam Q3 = 5'h08;
  localparam Q4 = 5'h10;
  localparam AM_INDEX = 4'h1;
  localparam AM_BANK = 4'h2;
  localparam AM_ACC_LO = 4'h4;
  localparam AM_ACC_HI = 4'h8;

  reg [4:0] state_r;
  reg [4:0] state_nxt;
  reg [15:0] instr_r;
  reg [11:0] addr_r;
  wire [WIDTH-1:0] result;
  wire dest_file;
  wire access_banked;
  wire [7:0] faddr;
  wire indexed;
  wire [7:0] idx_sum;
  wire [11:0] addr_nxt;
  wire opcode_ok;
  wire take;
  wire in_q1;
  wire in_q2;
  wire in_q3;
  reg [3:0] addr_mode;
  reg [11:0] addr_sel;
  reg file_wr_nxt;
  reg wreg_wr_nxt;
  reg flags_wr_nxt;
  reg neg_nxt;
  reg zero_nxt;
  reg [WIDTH-1:0] wreg_nxt;

  // ----------------------------------------
  // decode of the held instruction word
  // ----------------------------------------
  assign dest_file = instr_r[`RL_DEST_BIT];
  assign access_banked = instr_r[`RL_ACCESS_BIT];
  assign faddr = instr_r[7:0];
  assign indexed = ext_set_i && !access_banked && (faddr <= `RL_INDEX_LIMIT);
  assign idx_sum = index_base_i + faddr;

  // ----------------------------------------
  // phase decode
  // ----------------------------------------
  assign opcode_ok = (instr_r[`RL_OPC_HI:`RL_OPC_LO] == `RL_OPCODE);
  assign take = (state_r == IDLE) && start_i;
  assign in_q1 = (state_r == Q1);
  assign in_q2 = (state_r == Q2);
  assign in_q3 = (state_r == Q3);

  // ----------------------------------------
  // file address resolution
  // ----------------------------------------
  always @* begin
    if (indexed) begin
      addr_mode = AM_INDEX;
    end else if (access_banked) begin
      addr_mode = AM_BANK;
    end else if (faddr <= `RL_INDEX_LIMIT) begin
      addr_mode = AM_ACC_LO;
    end else begin
      addr_mode = AM_ACC_HI;
    end
  end

  // access bank low half lives in bank 0, high half in bank 15
  always @* begin
    case (addr_mode)
      AM_INDEX: addr_sel = {`RL_ACC_LO_BANK, idx_sum};
      AM_BANK: addr_sel = {bank_select_reg_i, faddr};
      AM_ACC_LO: addr_sel = {`RL_ACC_LO_BANK, faddr};
      AM_ACC_HI: addr_sel = {`RL_ACC_HI_BANK, faddr};
      default: addr_sel = {`RL_ACC_HI_BANK, faddr};
    endcase
  end
  assign addr_nxt = addr_sel;

  // ----------------------------------------
  // quarter phase sequencer
  // ----------------------------------------
  always @* begin
    state_nxt = state_r;
    case (state_r)
      IDLE: begin
        if (start_i) begin
          state_nxt = Q1;
        end
      end
      Q1: begin
        if (opcode_ok) begin
          state_nxt = Q2;
        end else begin
          state_nxt = IDLE;
        end
      end
      Q2: state_nxt = Q3;
      Q3: state_nxt = Q4;
      Q4: state_nxt = IDLE;
      default: state_nxt = IDLE;
    endcase
  end

  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_r <= IDLE;
      instr_r <= 16'h0000;
      addr_r <= 12'h000;
      illegal_o <= 1'b0;
    end else if (clk_en_i) begin
      state_r <= state_nxt;
      illegal_o <= 1'b0;
      if (take) begin
        instr_r <= instr_i;
      end
      if (in_q1) begin
        addr_r <= addr_nxt;
        illegal_o <= !opcode_ok;
      end
    end
  end

  assign busy_o = (state_r != IDLE);
  assign file_addr_o = addr_r;
  assign file_rd_o = in_q2;
  assign file_wdata_o = result;

  // ----------------------------------------
  // datapath: rotation latched at end of read phase
  // ----------------------------------------
  rot_left_bitrot #(
    .WIDTH(WIDTH)
  ) u_rot (
    .core_clk_i(core_clk_i),
    .arst_n_i(arst_n_i),
    .clk_en_i(clk_en_i),
    .load_i(in_q2),
    .data_i(file_rdata_i),
    .result_o(result)
  );

  // ----------------------------------------
  // destination write and flags
  // ----------------------------------------
  // strobes are one cycle wide; flags and working copy hold between writes
  always @* begin
    file_wr_nxt = in_q3 && dest_file;
    wreg_wr_nxt = in_q3 && !dest_file;
    flags_wr_nxt = in_q3;
    neg_nxt = neg_o;
    zero_nxt = zero_o;
    wreg_nxt = wreg_o;
    if (in_q3) begin
      neg_nxt = result[WIDTH-1];
      zero_nxt = (result == {WIDTH{1'b0}});
      if (!dest_file) begin
        wreg_nxt = result;
      end
    end
  end

  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wreg_o <= {WIDTH{1'b0}};
      wreg_wr_o <= 1'b0;
      file_wr_o <= 1'b0;
      neg_o <= 1'b0;
      zero_o <= 1'b0;
      flags_wr_o <= 1'b0;
    end else if (clk_en_i) begin
      file_wr_o <= file_wr_nxt;
      wreg_wr_o <= wreg_wr_nxt;
      flags_wr_o <= flags_wr_nxt;
      neg_o <= neg_nxt;
      zero_o <= zero_nxt;
      wreg_o <= wreg_nxt;
    end
  end
endmodule // rotate_left_no_carry_exec

// file: verif/rotate_left_no_carry_exec_asserts.sv
/* port checker for the rotate-left execution unit.
   assumes WIDTH 8 and stimulus held steady while busy. */
`timescale 1ns/1ps
module rotate_left_no_carry_exec_asserts #(parameter WIDTH = 8) (
  input wire core_clk_i,
  input wire arst_n_i,
  input wire clk_en_i,
  input wire start_i,
  input wire [15:0] instr_i,
  input wire ext_set_i,
  input wire [3:0] bank_select_reg_i,
  input wire [7:0] index_base_i,
  input wire [WIDTH-1:0] file_rdata_i,
  input wire [11:0] file_addr_o,
  input wire file_rd_o,
  input wire file_wr_o,
  input wire [WIDTH-1:0] file_wdata_o,
  input wire [WIDTH-1:0] wreg_o,
  input wire wreg_wr_o,
  input wire neg_o,
  input wire zero_o,
  input wire flags_wr_o,
  input wire busy_o,
  input wire illegal_o
);
  reg [15:0] ins_r;
  reg [3:0] bsr_r;
  reg [7:0] rd_r;
  wire [7:0] f = ins_r[7:0];
  wire low = f <= 8'h5f;
  wire [7:0] ix = index_base_i + f;
  wire [7:0] rot = {rd_r[6:0], rd_r[7]};
  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ins_r <= 16'h0;
      bsr_r <= 4'h0;
      rd_r <= 8'h00;
    end else if (clk_en_i) begin
      if (start_i && !busy_o) begin
        ins_r <= instr_i;
        bsr_r <= bank_select_reg_i;
      end
      if (file_rd_o) rd_r <= file_rdata_i;
    end
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i || !clk_en_i);
  sequence s_take; start_i && !busy_o && instr_i[15:10] == 6'h11; endsequence
  sequence s_phases; ##2 file_rd_o ##2 flags_wr_o; endsequence
  property p_phase; s_take |-> s_phases; endproperty
  property p_rot; flags_wr_o |-> file_wdata_o == rot; endproperty
  property p_dst_w; flags_wr_o && !ins_r[9] |-> wreg_wr_o && !file_wr_o && wreg_o == rot;
  endproperty
  property p_dst_f; flags_wr_o && ins_r[9] |->
    file_wr_o && !wreg_wr_o && file_addr_o == $past(file_addr_o, 2); endproperty
  property p_acc; file_rd_o && !ins_r[8] && !(ext_set_i && low) |->
    file_addr_o == {(low ? 4'h0 : 4'hf), f}; endproperty
  property p_bank; file_rd_o && ins_r[8] |-> file_addr_o == {bsr_r, f}; endproperty
  property p_idx; file_rd_o && !ins_r[8] && ext_set_i && low |-> file_addr_o == {4'h0, ix};
  endproperty
  sequence s_bad; start_i && !busy_o && instr_i[15:10] != 6'h11; endsequence
  property p_ill; s_bad |-> ##2 (illegal_o && !busy_o && !file_rd_o); endproperty
  property p_nz; flags_wr_o |-> neg_o == rot[7] && zero_o == (rot == 8'h00); endproperty
  property p_done; flags_wr_o |=> (!busy_o && !flags_wr_o); endproperty
  a_phase: assert property (p_phase) else $error("phase timing wrong");
  a_rot: assert property (p_rot) else $error("rotated byte wrong");
  a_dst_w: assert property (p_dst_w) else $error("working reg write wrong");
  a_dst_f: assert property (p_dst_f) else $error("file write-back wrong");
  a_acc: assert property (p_acc) else $error("access bank address wrong");
  a_bank: assert property (p_bank) else $error("banked address wrong");
  a_idx: assert property (p_idx) else $error("indexed address wrong");
  a_ill: assert property (p_ill) else $error("illegal opcode not flagged");
  a_nz: assert property (p_nz) else $error("result flags wrong");
  a_done: assert property (p_done) else $error("instruction did not finish");
endmodule // rotate_left_no_carry_exec_asserts
bind rotate_left_no_carry_exec rotate_left_no_carry_exec_asserts #(.WIDTH(WIDTH)) i_chk (.*);

// file: verif/rotate_left_no_carry_exec_tb_top.sv
/* random and corner bench for the rotate-left execution unit.
   assumes WIDTH 8; clock enable is dropped inside some instructions. */
`timescale 1ns/1ps
module rotate_left_no_carry_exec_tb_top;
  reg core_clk_i = 0, arst_n_i = 0, start_i = 0, ext_set_i = 0, clk_en_i = 1;
  reg [15:0] instr_i = 16'h0;
  reg [3:0] bank_select_reg_i = 4'h0;
  reg [7:0] index_base_i = 8'h00, file_rdata_i = 8'h00, lf = 8'h54, w_exp = 8'h00;
  wire [11:0] file_addr_o;
  wire [7:0] file_wdata_o, wreg_o;
  wire file_rd_o, file_wr_o, wreg_wr_o, flags_wr_o, busy_o, neg_o, zero_o, illegal_o;
  integer n_fail = 0, checks_done = 0, i, k;
  rotate_left_no_carry_exec #(.WIDTH(8)) i_rotate_left_no_carry_exec (
    .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .clk_en_i(clk_en_i), .start_i(start_i),
    .instr_i(instr_i), .ext_set_i(ext_set_i), .bank_select_reg_i(bank_select_reg_i),
    .index_base_i(index_base_i), .file_rdata_i(file_rdata_i), .file_addr_o(file_addr_o),
    .file_rd_o(file_rd_o), .file_wr_o(file_wr_o), .file_wdata_o(file_wdata_o), .wreg_o(wreg_o),
    .wreg_wr_o(wreg_wr_o), .neg_o(neg_o), .zero_o(zero_o), .flags_wr_o(flags_wr_o),
    .busy_o(busy_o), .illegal_o(illegal_o));
  function [7:0] nx(input [7:0] v); nx = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]}; endfunction
  function [11:0] ea(input [15:0] n);
    ea = n[8] ? {bank_select_reg_i, n[7:0]} : (n[7:0] > 8'h5f) ? {4'hf, n[7:0]} :
      ext_set_i ? {4'h0, 8'(index_base_i + n[7:0])} : {4'h0, n[7:0]};
  endfunction
  task chk(input [11:0] e, input [11:0] s, input [8*4:1] nm); begin
    checks_done = checks_done + 1;
    if (e !== s) begin
      n_fail = n_fail + 1;
      $display("mismatch %0s exp %h got %h", nm, e, s);
    end
  end endtask
  task op(input [15:0] n, input st); reg [7:0] r; begin
    @(posedge core_clk_i); #1 instr_i = n; start_i = 1;
    @(posedge core_clk_i); #1 start_i = 0;
    chk(12'h1, {11'h0, busy_o}, "busy");
    k = 0;
    while (file_rd_o !== 1'b1 && k < 9) begin @(posedge core_clk_i); #1 k = k + 1; end
    chk(12'h1, k[11:0], "rdph");
    if (st) begin
      clk_en_i = 0;
      repeat (3) @(posedge core_clk_i);
      #1 clk_en_i = 1;
      chk(12'h1, {11'h0, file_rd_o}, "frz");
    end
    chk(ea(n), file_addr_o, "addr");
    r = {file_rdata_i[6:0], file_rdata_i[7]};
    if (!n[9]) w_exp = r;
    k = 0;
    while (flags_wr_o !== 1'b1 && k < 9) begin @(posedge core_clk_i); #1 k = k + 1; end
    chk(12'h2, k[11:0], "phas");
    chk({4'h0, r}, {4'h0, file_wdata_o}, "data");
    chk({4'h0, w_exp}, {4'h0, wreg_o}, "wreg");
    chk({11'h0, n[9]}, {11'h0, file_wr_o}, "fwr");
    chk({10'h0, r[7], r == 8'h00}, {10'h0, neg_o, zero_o}, "nz");
  end endtask
  task bad(input [15:0] n); begin
    @(posedge core_clk_i); #1 instr_i = n; start_i = 1;
    @(posedge core_clk_i); #1 start_i = 0;
    @(posedge core_clk_i); #1 chk(12'h1, {11'h0, illegal_o}, "ill");
    chk(12'h0, {9'h0, busy_o, flags_wr_o, file_rd_o}, "idle");
  end endtask
  task results; begin
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  end endtask
  initial begin forever #2.5 core_clk_i = ~core_clk_i; end
  initial begin #20000; n_fail = n_fail + 1; results; end
  initial begin
    repeat (6) @(posedge core_clk_i);
    #1 arst_n_i = 1;
    file_rdata_i = 8'hab;
    op(16'h465f, 1'b0);
    ext_set_i = 1;
    index_base_i = 8'hff;
    op(16'h4460, 1'b0);
    op(16'h445f, 1'b1);
    file_rdata_i = 8'h00;
    op(16'h4700, 1'b0);
    bad(16'h4800);
    for (i = 0; i < 40; i = i + 1) begin
      lf = nx(lf); file_rdata_i = lf;
      lf = nx(lf); bank_select_reg_i = lf[3:0]; ext_set_i = lf[4];
      lf = nx(lf); index_base_i = lf;
      lf = nx(lf);
      op({6'h11, lf[1:0], nx(lf)}, lf[7]);
    end
    results;
  end
endmodule // rotate_left_no_carry_exec_tb_top
